// File: core/pbsp_port.sv
/*
 * Pipelined burst SRAM port: address capture by two strobes, chip select
 * qualification, burst counter, global and byte writes, registered data
 * input, pipelined read output and output enable masking.
 * Assumes the controller keeps the burst order strap static and drives
 * all synchronous pins relative to clk; the pad ring builds the wire
 * from dataOut and dataOe.
 */
// Function
// - address taken only with a strobe low and all chip selects active
// - capture loads the two low address bits into the burst counter
// - four active-low byte selects, qualified by byte enable, pick bytes
// - global write low writes all bytes, overriding byte controls
// - advance low increments the burst counter during a burst
// - selected only when select one low, two high, three low
// - chip selects looked at only when a new address is loaded
// - processor strobe ignored while select one is high
// - output enable low drives data pins, high releases them
// - first read clock after deselect keeps data pins released
// - processor strobe wins when both strobes are low
// - controller strobe captures address and loads counter bits
// - sleep input high idles the port, stored data kept
// - data pins captured into an input register on the clock edge
// - read data appears one clock after its address edge
// - processor-strobe write ignores write controls first cycle
// - data pins released whenever a write is detected
`timescale 1ns/1ps
`default_nettype none

module pbsp_port #(
   parameter int ADDR_W = pbsp_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // synchronous controls and address
   input  wire pbsp_pkg::pbsp_ctl_t  busCtl,
   input  wire logic [ADDR_W-1:0]    addrIn,
   // asynchronous controls and strap
   input  wire logic                 outputEnable_n,
   input  wire logic                 sleepReq,
   input  wire logic                 burstOrderStrap,
   // data and parity pins
   input  wire pbsp_pkg::pbsp_data_t dataIn,
   output var  pbsp_pkg::pbsp_data_t dataOut,
   output logic                      dataOe
);

   localparam int LANES  = pbsp_pkg::LANES;
   localparam int BYTE_W = pbsp_pkg::BYTE_W;
   localparam int LANE_W = pbsp_pkg::LANE_W;
   localparam int WORD_W = pbsp_pkg::WORD_W;
   localparam int BW     = pbsp_pkg::BURST_W;
   localparam int DEPTH  = 1 << ADDR_W;

   // reset release
   logic [1:0] rstPipe_r;
   logic       rstSync_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstPipe_r <= pbsp_pkg::RST_PIPE_INIT;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end

   assign rstSync_n = rstPipe_r[1];

   // access decode
   pbsp_pkg::pbsp_state_t state_r;
   pbsp_pkg::pbsp_state_t state_nxt;
   logic [ADDR_W-BW-1:0]  addrHi_r;
   logic [ADDR_W-BW-1:0]  addrHi_nxt;
   logic [BW-1:0]         curBits;
   logic [BW-1:0]         nxtBits;
   logic                  procHit;
   logic                  ctrlHit;
   logic                  load;
   logic                  chipSel;
   logic                  loadSel;
   logic                  selected;
   logic                  advance;
   logic                  active;
   logic                  writeReq;
   logic                  writeNow;
   logic                  readNow;
   logic [LANES-1:0]      laneMask;
   logic [ADDR_W-1:0]     accessAddr;

   always_comb begin
      selected = (state_r == pbsp_pkg::ST_SEL);
      procHit  = !busCtl.procAddrStrobe_n
                 && !busCtl.chipSelOne_n;
      ctrlHit  = !busCtl.ctrlAddrStrobe_n && !procHit;
      load     = (procHit || ctrlHit) && !sleepReq;
      chipSel  = !busCtl.chipSelOne_n && busCtl.chipSelTwo
                 && !busCtl.chipSelThree_n;
      loadSel  = load && chipSel;
      active   = (loadSel || (!load && selected)) && !sleepReq;
      advance  = !load && selected && !sleepReq
                 && !busCtl.burstAdvance_n;
      if (loadSel) begin
         accessAddr = addrIn;
      end else if (advance) begin
         accessAddr = {addrHi_r, nxtBits};
      end else begin
         accessAddr = {addrHi_r, curBits};
      end
      if (!busCtl.allBytesWrite_n) begin
         laneMask = pbsp_pkg::LANE_ALL;
      end else if (!busCtl.byteWriteEn_n) begin
         laneMask = ~busCtl.byteSelect_n;
      end else begin
         laneMask = pbsp_pkg::LANE_NONE;
      end
      writeReq = |laneMask;
      // processor strobe cycle treats write controls as absent
      writeNow = active && writeReq && !(loadSel && procHit);
      readNow  = active && !writeNow;
      state_nxt = state_r;
      if (load) begin
         state_nxt = chipSel ? pbsp_pkg::ST_SEL
                             : pbsp_pkg::ST_DESEL;
      end
      addrHi_nxt = loadSel ? addrIn[ADDR_W-1:BW] : addrHi_r;
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_r  <= pbsp_pkg::ST_DESEL;
         addrHi_r <= '0;
      end else begin
         state_r  <= state_nxt;
         addrHi_r <= addrHi_nxt;
      end
   end

   pbsp_burst_ctr #(
      .W          (BW)
   ) u_burst (
      .clk        (clk),
      .rst_n      (rstSync_n),
      .load       (loadSel),
      .loadBits   (addrIn[BW-1:0]),
      .advance    (advance),
      .linearMode (!burstOrderStrap),
      .curBits    (curBits),
      .nxtBits    (nxtBits)
   );

   // pipeline: issue stage and output stage
   logic                 rdPend_r;
   logic                 rdPend_nxt;
   logic [ADDR_W-1:0]    rdAddr_r;
   logic [ADDR_W-1:0]    rdAddr_nxt;
   logic                 wrPend_r;
   logic                 wrPend_nxt;
   logic [ADDR_W-1:0]    wrAddr_r;
   logic [ADDR_W-1:0]    wrAddr_nxt;
   logic [LANES-1:0]     wrMask_r;
   logic [LANES-1:0]     wrMask_nxt;
   pbsp_pkg::pbsp_data_t inData_r;
   pbsp_pkg::pbsp_data_t inData_nxt;
   pbsp_pkg::pbsp_data_t dataOut_nxt;
   logic                 drive_r;
   logic                 drive_nxt;
   logic [WORD_W-1:0]    rdWord;
   logic [WORD_W-1:0]    mem [0:DEPTH-1];

   always_comb begin
      rdPend_nxt = readNow;
      rdAddr_nxt = accessAddr;
      wrPend_nxt = writeNow;
      wrAddr_nxt = accessAddr;
      wrMask_nxt = writeNow ? laneMask : pbsp_pkg::LANE_NONE;
      inData_nxt = dataIn;
      rdWord     = mem[rdAddr_r];
      for (int i = 0; i < LANES; i++) begin
         dataOut_nxt.dq[i*BYTE_W +: BYTE_W] = rdWord[i*LANE_W +: BYTE_W];
         dataOut_nxt.parity[i] = rdWord[i*LANE_W + BYTE_W];
      end
      // data from the previous edge's address
      drive_nxt = rdPend_r;
      if (writeNow) begin
         drive_nxt = 1'b0;
      end
      if (load && !chipSel) begin
         drive_nxt = 1'b0;
      end
      if (loadSel && !selected) begin
         drive_nxt = 1'b0;
      end
      if (sleepReq) begin
         drive_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rdPend_r <= 1'b0;
         rdAddr_r <= '0;
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
         wrMask_r <= pbsp_pkg::LANE_NONE;
         inData_r <= '0;
         dataOut  <= '0;
         drive_r  <= 1'b0;
      end else begin
         rdPend_r <= rdPend_nxt;
         rdAddr_r <= rdAddr_nxt;
         wrPend_r <= wrPend_nxt;
         wrAddr_r <= wrAddr_nxt;
         wrMask_r <= wrMask_nxt;
         inData_r <= inData_nxt;
         dataOut  <= dataOut_nxt;
         drive_r  <= drive_nxt;
      end
   end

   // self-timed write from the input register, one edge after issue
   always_ff @(posedge clk) begin
      if (wrPend_r) begin
         for (int i = 0; i < LANES; i++) begin
            if (wrMask_r[i]) begin
               mem[wrAddr_r][i*LANE_W +: LANE_W] <=
                  {inData_r.parity[i], inData_r.dq[i*BYTE_W +: BYTE_W]};
            end
         end
      end
   end

   // asynchronous enable gating on top of the registered drive flag
   assign dataOe = drive_r && !outputEnable_n && !sleepReq;

endmodule

`default_nettype wire

// File: core/pbsp_pkg.sv
/*
 * Shared constants and types for the pipelined burst SRAM port: widths,
 * reset values, the access state encoding and the packed pin groups.
 * Assumes a single rising-edge clock domain around the port.
 */
package pbsp_pkg;

   // array geometry
   localparam int ADDR_W  = 19;
   localparam int LANES   = 4;
   localparam int BYTE_W  = 8;
   localparam int LANE_W  = 9;
   localparam int WORD_W  = 36;
   localparam int BURST_W = 2;

   // values after reset and the full lane mask
   localparam logic [1:0]         RST_PIPE_INIT = 2'h0;
   localparam logic [BURST_W-1:0] BURST_INIT    = 2'h0;
   localparam logic [LANES-1:0]   LANE_NONE     = 4'h0;
   localparam logic [LANES-1:0]   LANE_ALL      = 4'hF;

   typedef enum logic [1:0] {
      ST_DESEL = 2'b01,
      ST_SEL   = 2'b10
   } pbsp_state_t;

   // synchronous control pins, sampled on the rising clock edge
   typedef struct packed {
      logic             procAddrStrobe_n;
      logic             ctrlAddrStrobe_n;
      logic             burstAdvance_n;
      logic             allBytesWrite_n;
      logic             byteWriteEn_n;
      logic [LANES-1:0] byteSelect_n;
      logic             chipSelOne_n;
      logic             chipSelTwo;
      logic             chipSelThree_n;
   } pbsp_ctl_t;

   // data byte lanes with one parity bit per lane
   typedef struct packed {
      logic [LANES-1:0]        parity;
      logic [LANES*BYTE_W-1:0] dq;
   } pbsp_data_t;

endpackage

// File: core/pbsp_burst_ctr.sv
/*
 * Two-bit wraparound burst counter: holds the start bits of a burst and
 * a count, and presents the current and the next burst address bits.
 * Assumes load and advance are never asked for in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module pbsp_burst_ctr #(
   parameter int W = pbsp_pkg::BURST_W
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] loadBits,
   input  wire logic         advance,
   input  wire logic         linearMode,
   // burst address bits
   output logic      [W-1:0] curBits,
   output logic      [W-1:0] nxtBits
);

   logic [W-1:0] start_r;
   logic [W-1:0] start_nxt;
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic [W-1:0] countInc;

   always_comb begin
      start_nxt = start_r;
      count_nxt = count_r;
      countInc  = count_r + W'(1);
      if (load) begin
         start_nxt = loadBits;
         count_nxt = '0;
      end else if (advance) begin
         count_nxt = countInc;
      end
      // wrap inside the four-word group
      curBits = linearMode ? W'(start_r + count_r)
                           : (start_r ^ count_r);
      nxtBits = linearMode ? W'(start_r + countInc)
                           : (start_r ^ countInc);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_r <= W'(pbsp_pkg::BURST_INIT);
         count_r <= W'(pbsp_pkg::BURST_INIT);
      end else begin
         start_r <= start_nxt;
         count_r <= count_nxt;
      end
   end

endmodule

`default_nettype wire

// File: tb/pbsp_port_props.sv
/* pin-level checker for pbsp_port
   sees only top ports; bound to every pbsp_port instance */
`timescale 1ns/1ps
`default_nettype none
module pbsp_port_props (
   // clock and reset
   input wire logic                 clk,
   input wire logic                 reset_n,
   // controls
   input wire pbsp_pkg::pbsp_ctl_t  busCtl,
   input wire logic                 outputEnable_n,
   input wire logic                 sleepReq,
   // data side
   input wire pbsp_pkg::pbsp_data_t dataOut,
   input wire logic                 dataOe
);
   wire logic sel;
   wire logic cap;
   wire logic ctrlCap;
   wire logic wr;
   wire logic idle;
   wire logic desel;
   wire logic on;
   assign sel = !busCtl.chipSelOne_n && busCtl.chipSelTwo
                && !busCtl.chipSelThree_n;
   assign cap = !sleepReq && sel
                && !(busCtl.procAddrStrobe_n && busCtl.ctrlAddrStrobe_n);
   assign ctrlCap = cap && busCtl.procAddrStrobe_n;
   assign wr = !busCtl.allBytesWrite_n || !busCtl.byteWriteEn_n;
   assign idle = busCtl.procAddrStrobe_n && busCtl.ctrlAddrStrobe_n && !wr;
   assign desel = !sleepReq && !busCtl.ctrlAddrStrobe_n && !busCtl.chipSelTwo;
   assign on = !outputEnable_n && !sleepReq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_oe_release: assert property (outputEnable_n |-> !dataOe)
      else $error("data driven with output enable high");
   a_sleep_release: assert property (sleepReq |-> !dataOe)
      else $error("data driven while asleep");
   a_sleep_frozen: assert property (
      $past(sleepReq) |-> $stable(dataOut))
      else $error("read data changed while asleep");
   a_write_release: assert property (ctrlCap && wr |=> !dataOe)
      else $error("data driven after write issue");
   a_desel_release: assert property (desel |=> !dataOe)
      else $error("data driven after deselect");
   a_first_masked: assert property (
      desel ##1 (ctrlCap && !wr) |=> !dataOe)
      else $error("first read after deselect drove data");
   a_read_drives: assert property (
      ctrlCap && !wr ##1 idle |=> !on || dataOe)
      else $error("read data not driven one clock later");
   a_proc_priority: assert property (
      cap && !busCtl.procAddrStrobe_n && !busCtl.ctrlAddrStrobe_n
      ##1 idle |=> !on || dataOe)
      else $error("processor strobe cycle not taken as read");
   a_sel_ignored: assert property (
      idle && !busCtl.chipSelTwo && dataOe |=> !on || dataOe)
      else $error("selects acted on in a burst cycle");

   c_burst: cover property (ctrlCap && !wr ##1 !busCtl.burstAdvance_n && idle);
   c_write: cover property (ctrlCap && wr);
   c_sleep: cover property (sleepReq ##1 !sleepReq);
endmodule
bind pbsp_port pbsp_port_props i_pbsp_port_props (.clk, .reset_n, .busCtl,
   .outputEnable_n, .sleepReq, .dataOut, .dataOe);
`default_nettype wire

// File: tb/pbsp_ctrl_model.sv
/* controller side of the data wire
   resolves the shared lines from both drivers; no pull on the wire */
`timescale 1ns/1ps
`default_nettype none
module pbsp_ctrl_model (
   // clock
   input wire logic                  clk,
   // controller drive
   input wire logic                  ctrlDrive,
   input wire pbsp_pkg::pbsp_data_t  ctrlData,
   // port drive
   input wire pbsp_pkg::pbsp_data_t  dataOut,
   input wire logic                  dataOe,
   output var pbsp_pkg::pbsp_data_t dataIn
);
   pbsp_pkg::pbsp_data_t lastIn_r;
   // clash gives unknown; floating wire toggles
   always_comb begin
      if (ctrlDrive && dataOe)
         dataIn = 'x;
      else if (ctrlDrive)
         dataIn = ctrlData;
      else if (dataOe)
         dataIn = dataOut;
      else
         dataIn = ~lastIn_r;
   end
   always_ff @(posedge clk)
      lastIn_r <= dataIn;
endmodule
`default_nettype wire

// File: tb/pipelined_burst_sram_port_test.sv
/* scenario bench for pbsp_port with a shadow memory
   uses pbsp_ctrl_model for the wire; checker bound separately */
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_port_test;
   localparam logic [2:0] SEL = 3'h2;
   pbsp_pkg::pbsp_ctl_t  busCtl;
   pbsp_pkg::pbsp_data_t ctrlData;
   pbsp_pkg::pbsp_data_t dataIn;
   pbsp_pkg::pbsp_data_t dataOut;
   logic                 clk = 1'h0;
   logic                 reset_n = 1'h0;
   logic                 outputEnable_n = 1'h1;
   logic                 sleepReq = 1'h0;
   logic                 burstOrderStrap = 1'h0;
   logic                 ctrlDrive = 1'h0;
   logic                 dataOe;
   logic [2:0]           selCs = SEL;
   logic [5:0]           addrIn = 6'h00;
   logic [35:0]          mem [64];
   int                   num_errors = 0;
   int                   total_checks = 0;

   always #25 clk = ~clk;

   pbsp_port #(.ADDR_W(6)) i_pbsp_port (.clk, .reset_n, .busCtl, .addrIn,
      .outputEnable_n, .sleepReq, .burstOrderStrap, .dataIn, .dataOut,
      .dataOe);
   pbsp_ctrl_model i_pbsp_ctrl_model (.clk, .ctrlDrive, .ctrlData, .dataOut,
      .dataOe, .dataIn);

   function automatic pbsp_pkg::pbsp_ctl_t mk(logic [2:0] s, logic [1:0] w,
         logic [3:0] b);
      return pbsp_pkg::pbsp_ctl_t'({s, w, b, selCs});
   endfunction

   // one bus cycle; writes raise output enable and drive data
   task automatic step(logic [2:0] s, logic [1:0] w, logic [3:0] b,
         logic [5:0] a, logic [35:0] d);
      @(posedge clk);
      busCtl         <= mk(s, w, b);
      addrIn         <= a;
      ctrlData       <= d;
      ctrlDrive      <= (w != 2'h3);
      outputEnable_n <= (w != 2'h3);
   endtask

   task automatic chk(logic [36:0] seen, logic [36:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd(logic [35:0] exp);
      #1 chk({dataOe, dataOut}, {1'h1, exp});
   endtask

   task automatic off();
      #1 chk({36'h0, dataOe}, 37'h0);
   endtask

   task automatic idle2();
      repeat (2) step(3'h7, 2'h3, 4'hF, 6'h00, 36'h0);
   endtask

   task automatic s_write_byte();
      step(3'h5, 2'h0, 4'hE, 6'h04, 36'h1_1122_3344);
      step(3'h5, 2'h2, 4'hA, 6'h04, 36'hE_AABB_CCDD);
      step(3'h5, 2'h3, 4'hF, 6'h04, 36'h0);
      idle2();
      rd(36'h4_11BB_33DD);
   endtask

   task automatic s_burst(logic mode);
      int j;
      logic [1:0] lowBits;
      for (int i = 8; i < 12; i++) begin
         mem[i] = 36'h9_5A00_0000 + 36'(i);
         step(3'h5, 2'h1, 4'hF, 6'(i), mem[i]);
      end
      burstOrderStrap <= mode;
      step(3'h5, 2'h3, 4'hF, 6'h09, 36'h0);
      selCs = 3'h0;
      for (int k = 1; k < 7; k++) begin
         step(k < 4 ? 3'h6 : 3'h7, 2'h3, 4'hF, 6'h00, 36'h0);
         j = (k > 5) ? 3 : k - 2;
         lowBits = mode ? 2'h1 ^ 2'(j) : 2'h1 + 2'(j);
         if (k > 1)
            rd(mem[{4'h2, lowBits}]);
      end
      selCs = SEL;
   endtask

   task automatic s_proc();
      mem[12] = 36'h3_0F0F_0F0F;
      step(3'h5, 2'h1, 4'hF, 6'h0C, mem[12]);
      step(3'h1, 2'h1, 4'hF, 6'h0C, 36'h6_6666_6666);
      idle2();
      rd(mem[12]);
      mem[13] = 36'h5_1357_9BDF;
      step(3'h3, 2'h3, 4'hF, 6'h0D, 36'h0);
      step(3'h7, 2'h1, 4'hF, 6'h0D, mem[13]);
      step(3'h5, 2'h3, 4'hF, 6'h0D, 36'h0);
      idle2();
      rd(mem[13]);
   endtask

   task automatic s_desel();
      selCs = 3'h0;
      step(3'h5, 2'h3, 4'hF, 6'h0A, 36'h0);
      selCs = SEL;
      step(3'h5, 2'h3, 4'hF, 6'h0A, 36'h0);
      off();
      step(3'h7, 2'h3, 4'hF, 6'h00, 36'h0);
      off();
      selCs = 3'h6;
      step(3'h3, 2'h3, 4'hF, 6'h08, 36'h0);
      rd(mem[10]);
      selCs = SEL;
      idle2();
      rd(mem[10]);
   endtask

   task automatic s_sleep();
      @(posedge clk) sleepReq <= 1'h1;
      step(3'h5, 2'h1, 4'hF, 6'h0A, 36'h7_7777_7777);
      off();
      step(3'h7, 2'h3, 4'hF, 6'h00, 36'h0);
      sleepReq <= 1'h0;
      step(3'h5, 2'h3, 4'hF, 6'h0A, 36'h0);
      idle2();
      rd(mem[10]);
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      busCtl = mk(3'h7, 2'h3, 4'hF);
      ctrlData = 36'h0;
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge clk);
      s_write_byte();
      s_burst(1'h0);
      s_burst(1'h1);
      s_proc();
      s_desel();
      s_sleep();
      complete_run();
   end

   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
